// ===== src/fcr_readout.sv
// Frequency counter with result readout, enable register and APB slave
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module fcr_readout #(
	parameter int unsigned GATE_1MS_CYC = fcr_pkg::GATE_1MS_CYC,
	parameter int unsigned GATE_4MS_CYC = fcr_pkg::GATE_4MS_CYC,
	parameter int unsigned GATE_8MS_CYC = fcr_pkg::GATE_8MS_CYC,
	parameter int unsigned GATE_32MS_CYC = fcr_pkg::GATE_32MS_CYC,
	parameter int unsigned GATE_128MS_CYC = fcr_pkg::GATE_128MS_CYC
) (
	// Clock, enable and reset
	input wire logic REF_CLK,
	input wire logic CE,
	input wire logic SRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic PREADY,
	output logic [31:0] PRDATA,
	output logic PSLVERR,
	// Count input pins
	input wire logic FM_COUNT_IN,
	input wire logic AM_COUNT_IN,
	// Interrupt side
	input wire logic IRQ_ACK,
	output logic IRQ,
	output logic [7:0] IE3_ENABLES
);
	// Gate length in cycles for a gate code
	function automatic logic [31:0] gate_limit(input logic [2:0] code);
		case (code)
			fcr_pkg::GATE_8MS: gate_limit = 32'(GATE_8MS_CYC);
			fcr_pkg::GATE_32MS: gate_limit = 32'(GATE_32MS_CYC);
			fcr_pkg::GATE_128MS: gate_limit = 32'(GATE_128MS_CYC);
			fcr_pkg::GATE_1MS: gate_limit = 32'(GATE_1MS_CYC);
			fcr_pkg::GATE_4MS: gate_limit = 32'(GATE_4MS_CYC);
			default: gate_limit = 32'h0;
		endcase
	endfunction

	// Codes that may start a period; reserved codes refuse
	function automatic logic gate_ok(input logic [2:0] code);
		gate_ok = (gate_limit(code) != 32'h0) || (code == fcr_pkg::GATE_SOFT);
	endfunction

	// Control and status state
	fcr_pkg::fcr_mode_t mode_reg; // Run, gate, select, judge
	fcr_pkg::fcr_mode_t wmode; // Write data seen as mode
	fcr_pkg::fcr_state_t state_reg; // Counting or idle
	logic [18:0] cnt_reg; // The 19-bit count
	logic ovf_reg; // Sticky overflow flag
	logic [31:0] gate_cnt_reg; // Cycles into the gate
	logic [7:0] ie3_reg; // Third enable register
	logic [1:0] stat_reg; // Sticky event bits
	logic [1:0] mask_reg; // Event mask
	logic poll_reg; // Judge polling replaces interrupt
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic irq_reg;
	// Bus decode
	logic [9:0] idx;
	logic setup_acc; // Access phase, answer not yet given
	logic wr_done; // Write takes effect
	logic rd_done; // Read completes
	logic [31:0] rd_word;
	logic mapped;
	// Counter events
	logic [1:0] pin_edge; // Rising edges per pin
	logic cnt_edge;
	logic clr_pulse;
	logic start;
	logic stop_wr;
	logic period_end;
	logic ovf_event;
	logic [1:0] ev_set;

	assign idx = PADDR[11:2];
	assign wmode = fcr_pkg::fcr_mode_t'(PWDATA[7:0]);
	assign setup_acc = PSEL && PENABLE && !pready_reg;
	assign wr_done = PSEL && PENABLE && pready_reg && PWRITE;
	assign rd_done = PSEL && PENABLE && pready_reg && !PWRITE;

	// Pin synchronisers; third stage only feeds the edge detector
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			logic s1, s2, s3;
			always_ff @(posedge REF_CLK) begin
				if (SRST) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
				end else if (CE) begin
					s1 <= (g == 0) ? FM_COUNT_IN : AM_COUNT_IN;
					s2 <= s1;
					s3 <= s2;
				end
			end
			assign pin_edge[g] = s2 && !s3;
		end
	endgenerate

	// Input select: upper bit low disables both pins
	assign cnt_edge = mode_reg.sel[1] && (mode_reg.sel[0] ? pin_edge[1] : pin_edge[0]);

	// Mode register strobes
	assign clr_pulse = wr_done && (idx == fcr_pkg::IDX_MODE) && wmode.clr;
	assign start = wr_done && (idx == fcr_pkg::IDX_MODE) && wmode.run && !wmode.clr
		&& (state_reg == fcr_pkg::ST_IDLE) && gate_ok(wmode.gate);
	assign stop_wr = wr_done && (idx == fcr_pkg::IDX_MODE) && !wmode.run;
	// Timed gates end on the last cycle; soft gate ends when run is written 0
	assign period_end = (state_reg == fcr_pkg::ST_COUNT) && !clr_pulse && (stop_wr
		|| ((mode_reg.gate != fcr_pkg::GATE_SOFT)
		&& (gate_cnt_reg == gate_limit(mode_reg.gate) - 32'h1)));
	assign ovf_event = (state_reg == fcr_pkg::ST_COUNT) && cnt_edge && (&cnt_reg) && !clr_pulse;
	assign ev_set = {ovf_event, period_end && !poll_reg};

	// Sequencer
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			state_reg <= fcr_pkg::ST_IDLE;
		end else if (CE) begin
			if (clr_pulse) begin
				state_reg <= fcr_pkg::ST_IDLE;
			end else if (start) begin
				state_reg <= fcr_pkg::ST_COUNT;
			end else if (period_end) begin
				state_reg <= fcr_pkg::ST_IDLE;
			end
		end
	end

	// Gate timer
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			gate_cnt_reg <= 32'h0;
		end else if (CE) begin
			if (start || clr_pulse) begin
				gate_cnt_reg <= 32'h0;
			end else if (state_reg == fcr_pkg::ST_COUNT) begin
				gate_cnt_reg <= gate_cnt_reg + 32'h1;
			end
		end
	end

	// Count; frozen outside a period so the result holds
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			cnt_reg <= 19'h0;
		end else if (CE) begin
			if (clr_pulse || start) begin
				cnt_reg <= 19'h0;
			end else if ((state_reg == fcr_pkg::ST_COUNT) && cnt_edge) begin
				cnt_reg <= cnt_reg + 19'h1;
			end
		end
	end

	// Overflow flag; only the clear strobe removes it
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ovf_reg <= 1'b0;
		end else if (CE) begin
			if (clr_pulse) begin
				ovf_reg <= 1'b0;
			end else if (ovf_event) begin
				ovf_reg <= 1'b1;
			end
		end
	end

	// Mode register; clear bit is a strobe and reads back 0
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			mode_reg <= fcr_pkg::fcr_mode_t'(fcr_pkg::MODE_RST);
		end else if (CE) begin
			if (wr_done && (idx == fcr_pkg::IDX_MODE)) begin
				mode_reg.run <= wmode.run;
				mode_reg.gate <= wmode.gate;
				mode_reg.sel <= wmode.sel;
			end
			// Judge: period end beats a same-cycle read or acknowledge
			if (period_end) begin
				mode_reg.judge <= 1'b1;
			end else if ((rd_done && (idx == fcr_pkg::IDX_MODE)) || IRQ_ACK) begin
				mode_reg.judge <= 1'b0;
			end
			mode_reg.clr <= 1'b0;
		end
	end

	// Third enable register with set and clear aliases for bit access
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ie3_reg <= fcr_pkg::IE3_RST;
		end else if (CE && wr_done) begin
			if (idx == fcr_pkg::IDX_IE3) begin
				ie3_reg <= PWDATA[7:0] & fcr_pkg::IE3_IMPL_MASK;
			end else if (idx == fcr_pkg::IDX_IE3_SET) begin
				ie3_reg <= (ie3_reg | PWDATA[7:0]) & fcr_pkg::IE3_IMPL_MASK;
			end else if (idx == fcr_pkg::IDX_IE3_CLR) begin
				ie3_reg <= ie3_reg & ~PWDATA[7:0];
			end
		end
	end

	// Event status, mask and polling choice; a new event beats write-one-clear
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			stat_reg <= fcr_pkg::EV_RST;
			mask_reg <= fcr_pkg::EV_RST;
			poll_reg <= 1'b0;
		end else if (CE) begin
			if (wr_done && (idx == fcr_pkg::IDX_IRQ_STAT)) begin
				stat_reg <= (stat_reg & ~PWDATA[1:0]) | ev_set;
			end else begin
				stat_reg <= stat_reg | ev_set;
			end
			if (wr_done && (idx == fcr_pkg::IDX_IRQ_MASK)) begin
				mask_reg <= PWDATA[1:0];
			end
			if (wr_done && (idx == fcr_pkg::IDX_IRQ_CFG)) begin
				poll_reg <= PWDATA[0];
			end
		end
	end

	// Interrupt request gated by the enable bit
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			irq_reg <= 1'b0;
		end else if (CE) begin
			irq_reg <= (|(stat_reg & mask_reg)) && ie3_reg[fcr_pkg::IE3_FC_BIT];
		end
	end

	// Read mux; result bytes have no write path at all
	always_comb begin
		mapped = 1'b1;
		rd_word = 32'h0;
		case (idx)
			fcr_pkg::IDX_IE3, fcr_pkg::IDX_IE3_SET, fcr_pkg::IDX_IE3_CLR: begin
				rd_word = {24'h0, ie3_reg};
			end
			fcr_pkg::IDX_MODE: begin
				rd_word = {24'h0, mode_reg};
			end
			fcr_pkg::IDX_UPPER: begin
				rd_word = {28'h0, ovf_reg, cnt_reg[18:16]};
			end
			fcr_pkg::IDX_MIDDLE: begin
				rd_word = {24'h0, cnt_reg[15:8]};
			end
			fcr_pkg::IDX_LOW: begin
				rd_word = {24'h0, cnt_reg[7:0]};
			end
			fcr_pkg::IDX_IRQ_STAT: begin
				rd_word = {30'h0, stat_reg};
			end
			fcr_pkg::IDX_IRQ_MASK: begin
				rd_word = {30'h0, mask_reg};
			end
			fcr_pkg::IDX_IRQ_CFG: begin
				rd_word = {31'h0, poll_reg};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// APB answer: one wait cycle, then ready with data or error
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0;
			pslverr_reg <= 1'b0;
		end else if (CE) begin
			pready_reg <= setup_acc;
			pslverr_reg <= setup_acc && !mapped;
			if (setup_acc) begin
				prdata_reg <= PWRITE ? 32'h0 : rd_word;
			end
		end
	end

	assign PREADY = pready_reg;
	assign PRDATA = prdata_reg;
	assign PSLVERR = pslverr_reg;
	assign IRQ = irq_reg;
	assign IE3_ENABLES = ie3_reg;

	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	a_irq_needs_enable: assert property (IRQ |-> $past(ie3_reg[fcr_pkg::IE3_FC_BIT]))
		else $error("Interrupt raised with counter enable off");
	a_ovf_held: assert property (CE && ovf_reg && !clr_pulse |=> ovf_reg)
		else $error("Overflow flag dropped without clear");
	a_clear_all: assert property (CE && clr_pulse |=> cnt_reg == 19'h0 && !ovf_reg
		&& state_reg == fcr_pkg::ST_IDLE)
		else $error("Clear did not reset counter");
	a_result_hold: assert property (CE && state_reg == fcr_pkg::ST_IDLE && !start && !clr_pulse
		|=> $stable(cnt_reg))
		else $error("Result changed outside a period");
	a_judge_set: assert property (CE && period_end |=> mode_reg.judge ##1 1'b1)
		else $error("Judge flag not set at period end");
	a_no_sel_count: assert property (CE && !mode_reg.sel[1] && !start && !clr_pulse
		|=> $stable(cnt_reg))
		else $error("Counted with inputs disabled");
	a_gate_bound: assert property (state_reg == fcr_pkg::ST_COUNT && mode_reg.gate != fcr_pkg::GATE_SOFT
		|-> gate_cnt_reg < gate_limit(mode_reg.gate))
		else $error("Gate ran past its length");
	a_upper_read: assert property (CE && setup_acc && !PWRITE && idx == fcr_pkg::IDX_UPPER
		|=> PREADY && PRDATA == {28'h0, $past(ovf_reg), $past(cnt_reg[18:16])})
		else $error("Upper byte read wrong");
	a_middle_read: assert property (CE && setup_acc && !PWRITE && idx == fcr_pkg::IDX_MIDDLE
		|=> PRDATA[7:0] == $past(cnt_reg[15:8]))
		else $error("Middle byte read wrong");
	a_low_read: assert property (CE && setup_acc && !PWRITE && idx == fcr_pkg::IDX_LOW
		|=> PRDATA[7:0] == $past(cnt_reg[7:0]))
		else $error("Low byte read wrong");
	a_ie3_write: assert property (CE && wr_done && idx == fcr_pkg::IDX_IE3
		|=> ie3_reg == ($past(PWDATA[7:0]) & fcr_pkg::IE3_IMPL_MASK))
		else $error("Enable register write lost");
endmodule

// ===== pkg/fcr_pkg.sv
// Shared constants and types for the frequency counter readout block
package fcr_pkg;
	// Clock rate and gate times
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned GATE_1MS_US = 1000;
	localparam int unsigned GATE_4MS_US = 4000;
	localparam int unsigned GATE_8MS_US = 8000;
	localparam int unsigned GATE_32MS_US = 32000;
	localparam int unsigned GATE_128MS_US = 128000;
	// Cycles per gate time, exact at whole MHz
	localparam int unsigned GATE_1MS_CYC = GATE_1MS_US * CLK_MHZ;
	localparam int unsigned GATE_4MS_CYC = GATE_4MS_US * CLK_MHZ;
	localparam int unsigned GATE_8MS_CYC = GATE_8MS_US * CLK_MHZ;
	localparam int unsigned GATE_32MS_CYC = GATE_32MS_US * CLK_MHZ;
	localparam int unsigned GATE_128MS_CYC = GATE_128MS_US * CLK_MHZ;
	// Widths
	localparam int unsigned CNT_W = 19;
	localparam int unsigned IDX_W = 10;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_IE3 = 10'h0c0;
	localparam logic [9:0] IDX_IE3_SET = 10'h0c1;
	localparam logic [9:0] IDX_IE3_CLR = 10'h0c2;
	localparam logic [9:0] IDX_MODE = 10'h0f4;
	localparam logic [9:0] IDX_UPPER = 10'h0f5;
	localparam logic [9:0] IDX_MIDDLE = 10'h0f6;
	localparam logic [9:0] IDX_LOW = 10'h0f7;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h0f8;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h0f9;
	localparam logic [9:0] IDX_IRQ_CFG = 10'h0fa;
	// Field positions
	localparam int unsigned IE3_FC_BIT = 4;
	localparam logic [7:0] IE3_IMPL_MASK = 8'h7f;
	localparam int unsigned EV_END_BIT = 0;
	localparam int unsigned EV_OVF_BIT = 1;
	// Reset values
	localparam logic [7:0] IE3_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [1:0] EV_RST = 2'h0;
	// Gate time codes
	localparam logic [2:0] GATE_8MS = 3'h0;
	localparam logic [2:0] GATE_32MS = 3'h1;
	localparam logic [2:0] GATE_128MS = 3'h2;
	localparam logic [2:0] GATE_SOFT = 3'h3;
	localparam logic [2:0] GATE_1MS = 3'h4;
	localparam logic [2:0] GATE_4MS = 3'h5;
	// Mode register layout, msb first
	typedef struct packed {
		logic judge;
		logic run;
		logic clr;
		logic [2:0] gate;
		logic [1:0] sel;
	} fcr_mode_t;
	// Counter sequencing
	typedef enum logic {ST_IDLE, ST_COUNT} fcr_state_t;
endpackage

// ===== sim/fcr_pulse_src.sv
// Model of the external intermediate-frequency source on the count pins
`timescale 1ns/100ps
module fcr_pulse_src (
	// Clock
	input wire logic clk,
	// Count pins, idle low between bursts
	output logic fm,
	output logic am
);
	// Both pins start quiet
	initial begin
		fm = 1'b0;
		am = 1'b0;
	end
	// Burst of n rising edges, two cycles high and two low so the synchroniser sees each
	task automatic send(input logic pin, input int n);
		for (int i = 0; i < n; i++) begin
			if (pin) am <= 1'b1; else fm <= 1'b1;
			repeat (2) @(posedge clk);
			am <= 1'b0;
			fm <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
endmodule

// ===== sim/tb_freq_counter_readout.sv
// Self-checking testbench for the frequency counter readout block
`timescale 1ns/100ps
module tb_freq_counter_readout;
	// Bench side of every port
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, ack = 0, ce = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, pslverr, irq, fm, am, e;
	logic [7:0] ens;
	int bad_count = 0, checks_done = 0, cyc = 0;
	// Byte addresses are four times the register index
	localparam logic [11:0] A_IE3 = {fcr_pkg::IDX_IE3, 2'b00};
	localparam logic [11:0] A_SET = {fcr_pkg::IDX_IE3_SET, 2'b00};
	localparam logic [11:0] A_CLR = {fcr_pkg::IDX_IE3_CLR, 2'b00};
	localparam logic [11:0] A_MODE = {fcr_pkg::IDX_MODE, 2'b00};
	localparam logic [11:0] A_UP = {fcr_pkg::IDX_UPPER, 2'b00};
	localparam logic [11:0] A_MID = {fcr_pkg::IDX_MIDDLE, 2'b00};
	localparam logic [11:0] A_LOW = {fcr_pkg::IDX_LOW, 2'b00};
	localparam logic [11:0] A_ST = {fcr_pkg::IDX_IRQ_STAT, 2'b00};
	localparam logic [11:0] A_MSK = {fcr_pkg::IDX_IRQ_MASK, 2'b00};
	localparam logic [11:0] A_CFG = {fcr_pkg::IDX_IRQ_CFG, 2'b00};
	// Short gates keep the run brief
	fcr_readout #(.GATE_1MS_CYC(20), .GATE_4MS_CYC(30), .GATE_8MS_CYC(40), .GATE_32MS_CYC(50),
		.GATE_128MS_CYC(60)) dut (.REF_CLK(clk), .CE(ce), .SRST(srst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
		.PSLVERR(pslverr), .FM_COUNT_IN(fm), .AM_COUNT_IN(am), .IRQ_ACK(ack), .IRQ(irq),
		.IE3_ENABLES(ens));
	// Far-side signal source
	fcr_pulse_src src (.clk(clk), .fm(fm), .am(am));
	// 250 MHz clock
	always #2 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			test_done;
		end
	end
	// Verdict
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) bad_count++;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// Reset values and an unmapped place
	task automatic t_reset;
		rdc(A_IE3, 32'h0);
		rdc(A_UP, 32'h0);
		apb(1'b0, 12'hffc, 32'h0);
		chk(e, 1'b1);
	endtask
	// Enable register, direct and bitwise
	task automatic t_enable;
		wr(A_IE3, 32'h7f);
		rdc(A_IE3, 32'h7f);
		chk(ens, 8'h7f);
		wr(A_CLR, 32'h10);
		rdc(A_IE3, 32'h6f);
		wr(A_SET, 32'h10);
		rdc(A_IE3, 32'h7f);
	endtask
	// Soft gate: 291 edges split over the bytes, then read-only and clear
	task automatic t_soft;
		wr(A_MODE, 32'h4e);
		src.send(1'b0, 291);
		repeat (6) @(posedge clk);
		wr(A_MODE, 32'h0e);
		rdc(A_UP, 32'h0);
		rdc(A_MID, 32'h01);
		rdc(A_LOW, 32'h23);
		wr(A_LOW, 32'hff);
		rdc(A_LOW, 32'h23);
		wr(A_MODE, 32'h20);
		rdc(A_LOW, 32'h0);
	endtask
	// Clock enable low: pin edges meanwhile must not be counted
	task automatic t_freeze;
		wr(A_MODE, 32'h4e);
		src.send(1'b0, 4);
		repeat (6) @(posedge clk);
		ce <= 1'b0;
		src.send(1'b0, 4);
		repeat (2) @(posedge clk);
		ce <= 1'b1;
		repeat (6) @(posedge clk);
		wr(A_MODE, 32'h0e);
		rdc(A_LOW, 32'h04);
	endtask
	// Input select: AM counted, AM ignored under FM, pins disabled
	task automatic t_select;
		logic [1:0] sel [3] = '{2'h3, 2'h2, 2'h0};
		logic [7:0] exp [3] = '{8'h05, 8'h00, 8'h00};
		for (int i = 0; i < 3; i++) begin
			wr(A_MODE, {24'h0, 6'h13, sel[i]});
			src.send(i != 2, 5);
			repeat (6) @(posedge clk);
			wr(A_MODE, {24'h0, 6'h03, sel[i]});
			rdc(A_LOW, {24'h0, exp[i]});
		end
	endtask
	// Timed gates, judge flag, enable gating, ack, reserved code
	task automatic t_gates;
		logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
		int len [5] = '{40, 50, 60, 20, 30};
		int n;
		wr(A_ST, 32'h3);
		wr(A_MSK, 32'h1);
		wr(A_IE3, 32'h10);
		for (int i = 0; i < 5; i++) begin
			wr(A_MODE, {24'h0, 3'h2, code[i], 2'h2});
			n = 0;
			while (irq !== 1'b1 && n < 200) begin
				@(posedge clk);
				n++;
			end
			chk(n >= len[i] && n <= len[i] + 5, 1'b1);
			apb(1'b0, A_MODE, 32'h0);
			chk(rd[7], 1'b1);
			apb(1'b0, A_MODE, 32'h0);
			chk(rd[7], 1'b0);
			wr(A_ST, 32'h1);
			repeat (2) @(posedge clk);
			chk(irq, 1'b0);
		end
		// Polling the judge flag keeps the request quiet
		wr(A_CFG, 32'h1);
		wr(A_MODE, 32'h52);
		repeat (40) @(posedge clk);
		chk(irq, 1'b0);
		rdc(A_ST, 32'h0);
		apb(1'b0, A_MODE, 32'h0);
		chk(rd[7], 1'b1);
		wr(A_CFG, 32'h0);
		// Request held back while the enable is off
		wr(A_IE3, 32'h0);
		wr(A_MODE, 32'h52);
		repeat (40) @(posedge clk);
		chk(irq, 1'b0);
		wr(A_IE3, 32'h10);
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		apb(1'b0, A_MODE, 32'h0);
		chk(rd[7], 1'b0);
		wr(A_ST, 32'h3);
		// Reserved gate code starts nothing
		wr(A_MODE, 32'h5a);
		src.send(1'b0, 3);
		repeat (100) @(posedge clk);
		chk(irq, 1'b0);
		rdc(A_LOW, 32'h0);
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_enable;
		t_soft;
		t_freeze;
		t_select;
		t_gates;
		test_done;
	end
endmodule
